// file: verilog/nfcs_top.sv
// NOR flash controller: control, status and sector registers with operation sequencing
//
// Contract
// - With program_lock clear, program and erase on guarded sectors may proceed.
// - program_lock is control bit 7, resets 0; when set, boot-sector program/erase refused.
// - Writing 1 to flash_array_reset pulses the array reset for at least 500ns.
// - flash_array_reset clears itself when the array reset has finished.
// - Writing 1 to ctrl_only_reset resets only the controller, not the array.
// - write_high_word_accepted sets on handshake fall in high-word write; clears on erase start.
// - write_low_word_accepted sets on handshake fall in low-word write; clears on write start.
// - erase_accepted sets on handshake fall during erase; clears on next erase start.
// - irq_flag reads 1 once the controller has raised an interrupt.
// - Status bits 7 to 3 mirror flash data lines 7, 6, 5, 3, 2.
// - op_done reads 1 when a controller operation has completed.
// - flash_ctrl_idle reads 1 while controller idle, 0 while busy.
// - nor_array_idle reads 1 while flash array idle, 0 while busy.
// - Software loads sector_select before an operation; controller applies it.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module nfcs_top
  import nfcs_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic nor_reset_n,
  output logic nor_op_req,
  output logic [1:0] nor_op_cmd,
  output logic [SECTOR_W-1:0] nor_sector,
  output logic [31:0] nor_wdata,
  input wire logic flash_busy_handshake_n,
  input wire logic nor_array_ready,
  input wire logic [7:0] flash_dq
);
  typedef enum logic [1:0] {S_IDLE, S_REQ, S_BUSY} nfcs_state_e;

  nfcs_reg_if rif ();

  nfcs_axil_slave u_slave (
    .mclk(mclk),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic busy_n_m;
  logic busy_n_s;
  logic busy_n_d;
  logic ready_m;
  logic ready_s;
  logic [7:0] dq_m;
  logic [7:0] dq_s;
  logic busy_fall;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_n_m <= 1'b1;
      busy_n_s <= 1'b1;
      busy_n_d <= 1'b1;
      ready_m <= 1'b0;
      ready_s <= 1'b0;
      dq_m <= '0;
      dq_s <= '0;
    end else begin
      busy_n_m <= flash_busy_handshake_n;
      busy_n_s <= busy_n_m;
      busy_n_d <= busy_n_s;
      ready_m <= nor_array_ready;
      ready_s <= ready_m;
      dq_m <= flash_dq;
      dq_s <= dq_m;
    end
  end

  // Edge taken after the synchroniser; a fall shorter than one clock may be missed
  assign busy_fall = busy_n_d && !busy_n_s;

  //////////////////////////////////////////////////////////////////////////////
  // Register writes
  logic wr_control;
  logic wr_command;
  logic program_lock;
  logic [SECTOR_W-1:0] sector_select;
  logic [31:0] write_word;
  logic ctl_rst;
  logic arst_req;
  logic [6:0] arst_cnt;

  assign wr_control = rif.wr_en && rif.wr_addr == OFS_CONTROL && rif.wr_strb[0];
  assign wr_command = rif.wr_en && rif.wr_addr == OFS_COMMAND && rif.wr_strb[0];
  assign ctl_rst = wr_control && rif.wr_data[CTL_CRST];
  assign arst_req = wr_control && rif.wr_data[CTL_ARST];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      program_lock <= CONTROL_RESET[CTL_LOCK];
    end else if (wr_control) begin
      program_lock <= rif.wr_data[CTL_LOCK];
    end
  end

  // Status offset has no write path, so software writes to it fall through
  logic [31:0] sector_merged;
  assign sector_merged = nfcs_merge(32'(sector_select), rif.wr_data, rif.wr_strb);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sector_select <= SECTOR_RESET[SECTOR_W-1:0];
    end else if (rif.wr_en && rif.wr_addr == OFS_SECTOR) begin
      sector_select <= sector_merged[SECTOR_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      write_word <= '0;
    end else if (rif.wr_en && rif.wr_addr == OFS_WDATA) begin
      write_word <= nfcs_merge(write_word, rif.wr_data, rif.wr_strb);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array reset timer; the controller reset does not touch it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      nor_reset_n <= 1'b1;
      arst_cnt <= '0;
    end else if (nor_reset_n) begin
      if (arst_req) begin
        nor_reset_n <= 1'b0;
        arst_cnt <= ARST_CYC - 7'h01;
      end
    end else if (arst_cnt == 7'h00) begin
      nor_reset_n <= 1'b1;
    end else begin
      arst_cnt <= arst_cnt - 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  nfcs_state_e state;
  nfcs_op_e cmd_op;
  nfcs_op_e cur_op;
  logic start_try;
  logic is_prog;
  logic prot_hit;
  logic refused;
  logic start_ok;
  logic finish;

  assign cmd_op = nfcs_op_e'(rif.wr_data[1:0]);
  assign start_try = wr_command && state == S_IDLE && nor_reset_n && !ctl_rst;
  assign is_prog = cmd_op != OP_READ;
  assign prot_hit = sector_select == PROT_SEC0 || sector_select == PROT_SEC1 ||
                    sector_select == PROT_SEC2 || sector_select == PROT_SEC3;
  assign refused = start_try && is_prog && program_lock && prot_hit;
  assign start_ok = start_try && !refused;
  assign finish = state == S_BUSY && busy_n_s;
  assign nor_op_req = state == S_REQ;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
    end else if (ctl_rst) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (start_ok) begin
            state <= S_REQ;
          end
        end
        S_REQ: begin
          if (busy_fall) begin
            state <= S_BUSY;
          end
        end
        S_BUSY: begin
          if (busy_n_s) begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Operation fields are frozen at start so later register writes cannot disturb the flash
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cur_op <= OP_READ;
      nor_op_cmd <= 2'h0;
      nor_sector <= '0;
      nor_wdata <= '0;
    end else if (start_ok) begin
      cur_op <= cmd_op;
      nor_op_cmd <= rif.wr_data[1:0];
      nor_sector <= sector_select;
      nor_wdata <= write_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags; the set is written last so it beats a same-cycle clear, except that a controller reset beats completion for irq_flag and op_done
  logic flag_wh;
  logic flag_wl;
  logic flag_es;
  logic irq_flag;
  logic op_done;
  logic accept;

  assign accept = state == S_REQ && busy_fall;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flag_wh <= STATUS_RESET[ST_WH];
      flag_wl <= STATUS_RESET[ST_WL];
      flag_es <= STATUS_RESET[ST_ES];
    end else begin
      if (start_ok && cmd_op == OP_ERASE) begin
        flag_wh <= 1'b0;
        flag_es <= 1'b0;
      end
      if (start_ok && (cmd_op == OP_WRITE_HIGH || cmd_op == OP_WRITE_LOW)) begin
        flag_wl <= 1'b0;
      end
      if (accept && cur_op == OP_WRITE_HIGH) begin
        flag_wh <= 1'b1;
      end
      if (accept && cur_op == OP_WRITE_LOW) begin
        flag_wl <= 1'b1;
      end
      if (accept && cur_op == OP_ERASE) begin
        flag_es <= 1'b1;
      end
    end
  end

  // A refused start raises the interrupt flag too, so software sees the refusal
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_flag <= STATUS_RESET[ST_IRQ];
      op_done <= STATUS_RESET[ST_DONE];
    end else begin
      if (start_ok || ctl_rst) begin
        irq_flag <= 1'b0;
        op_done <= 1'b0;
      end
      if (finish && !ctl_rst) begin
        irq_flag <= 1'b1;
        op_done <= 1'b1;
      end
      if (refused) begin
        irq_flag <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] status_word;
  logic [31:0] control_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_WH] = flag_wh;
    status_word[ST_WL] = flag_wl;
    status_word[ST_ES] = flag_es;
    status_word[ST_IRQ] = irq_flag;
    status_word[ST_DQ +: 5] = {dq_s[7], dq_s[6], dq_s[5], dq_s[3], dq_s[2]};
    status_word[ST_DONE] = op_done;
    status_word[ST_CIDLE] = state == S_IDLE;
    status_word[ST_AIDLE] = ready_s;
  end

  always_comb begin
    control_word = 32'h0000_0000;
    control_word[CTL_LOCK] = program_lock;
    control_word[CTL_ARST] = !nor_reset_n;
  end

  always_comb begin
    unique case (rif.rd_addr)
      OFS_CONTROL: rif.rd_data = control_word;
      OFS_STATUS: rif.rd_data = status_word;
      OFS_SECTOR: rif.rd_data = 32'(sector_select);
      OFS_WDATA: rif.rd_data = write_word;
      default: rif.rd_data = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [7:0] low_len;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      low_len <= '0;
    end else if (nor_reset_n) begin
      low_len <= '0;
    end else begin
      low_len <= low_len + 8'h01;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_lock_refuse: assert property (
    refused |=> state == S_IDLE && irq_flag && op_done == $past(op_done))
    else $error("protected program or erase was not refused");

  a_unlock_accept: assert property (
    start_try && is_prog && !program_lock |=> state == S_REQ && nor_op_req)
    else $error("unlocked program or erase did not start");

  a_arst_width: assert property (
    $rose(nor_reset_n) |-> low_len == 8'(ARST_CYCLES))
    else $error("array reset pulse length wrong");

  a_arst_selfclr: assert property (
    nor_reset_n && arst_req |=> control_word[CTL_ARST] && !nor_reset_n ##99
    control_word[CTL_ARST] ##1 (nor_reset_n && !control_word[CTL_ARST]))
    else $error("array reset bit did not clear after the pulse");

  a_crst_only: assert property (
    ctl_rst |=> state == S_IDLE && nor_reset_n == $past(nor_reset_n))
    else $error("controller reset misbehaved");

  a_wh_sticky: assert property (
    flag_wh && !(start_ok && cmd_op == OP_ERASE) |=> flag_wh)
    else $error("high word accepted flag dropped early");

  a_wl_set: assert property (
    accept && cur_op == OP_WRITE_LOW |=> flag_wl ##1 (flag_wl || wr_command))
    else $error("low word accepted flag not set");

  a_es_set: assert property (
    accept && cur_op == OP_ERASE |=> flag_es && state == S_BUSY)
    else $error("erase accepted flag not set");

  a_done_irq: assert property (
    finish && !ctl_rst |=> op_done && irq_flag && status_word[ST_CIDLE])
    else $error("completion not reported");

  a_ctrl_busy: assert property (
    start_ok |=> !status_word[ST_CIDLE] [*2])
    else $error("controller idle bit wrong while busy");

  a_sector_apply: assert property (
    start_ok |=> nor_sector == $past(sector_select))
    else $error("sector not applied to operation");

  a_dq_mirror: assert property (
    status_word[ST_DQ +: 5] == {$past(dq_m[7]), $past(dq_m[6]), $past(dq_m[5]),
                                $past(dq_m[3]), $past(dq_m[2])})
    else $error("data line mirror wrong");

  c_erase_flow: cover property (accept && cur_op == OP_ERASE ##[1:50] finish);
  c_refused: cover property (refused);
  c_arst_done: cover property ($rose(nor_reset_n));
  c_write_high: cover property (accept && cur_op == OP_WRITE_HIGH);
endmodule : nfcs_top
`default_nettype wire

// file: verilog/nfcs_pkg.sv
// Register map, field positions and timing of the NOR flash control and status block
`default_nettype none
package nfcs_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int SECTOR_W = 22;
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_SECTOR = 5'h08;
  localparam logic [4:0] OFS_COMMAND = 5'h0C;
  localparam logic [4:0] OFS_WDATA = 5'h10;
  localparam int CTL_LOCK = 7;
  localparam int CTL_ARST = 1;
  localparam int CTL_CRST = 0;
  localparam int ST_WH = 11;
  localparam int ST_WL = 10;
  localparam int ST_ES = 9;
  localparam int ST_IRQ = 8;
  localparam int ST_DQ = 3;
  localparam int ST_DONE = 2;
  localparam int ST_CIDLE = 1;
  localparam int ST_AIDLE = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] SECTOR_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ARST_MIN_NS = 500;
  localparam int ARST_CYCLES = (ARST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [6:0] ARST_CYC = 7'(ARST_CYCLES);
  localparam logic [21:0] PROT_SEC0 = 22'h00_0000;
  localparam logic [21:0] PROT_SEC1 = 22'h00_0001;
  localparam logic [21:0] PROT_SEC2 = 22'h00_008C;
  localparam logic [21:0] PROT_SEC3 = 22'h00_008D;
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE_HIGH = 2'h1,
    OP_WRITE_LOW = 2'h2,
    OP_ERASE = 2'h3
  } nfcs_op_e;
  function automatic logic nfcs_mapped(input logic [31:0] addr);
    return (addr[31:ADDR_W] == 27'h000_0000) && (addr[1:0] == 2'h0) &&
      (addr[4:0] <= OFS_WDATA);
  endfunction : nfcs_mapped
  function automatic logic [31:0] nfcs_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : nfcs_merge
endpackage : nfcs_pkg
`default_nettype wire

// file: verilog/nfcs_reg_if.sv
// Register access channel between the bus slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface nfcs_reg_if;
  import nfcs_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb,
               output rd_addr, input rd_data);
  modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb,
                input rd_addr, output rd_data);
endinterface : nfcs_reg_if
`default_nettype wire

// file: verilog/nfcs_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
module nfcs_axil_slave
  import nfcs_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  nfcs_reg_if.bus rif
);
  logic aw_got;
  logic w_got;
  logic aw_ok;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;

  // Address and data may arrive in either order; each is parked until both are held
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign wr_fire = aw_got && w_got;
  assign rif.wr_en = wr_fire && aw_ok;
  assign rif.wr_addr = aw_addr;
  assign rif.wr_data = w_data;
  assign rif.wr_strb = w_strb;
  assign rif.rd_addr = s_axi_araddr[ADDR_W-1:0];
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      aw_got <= 1'b0;
      aw_ok <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got <= 1'b1;
      aw_ok <= nfcs_mapped(s_axi_awaddr);
      aw_addr <= s_axi_awaddr[ADDR_W-1:0];
    end else if (wr_fire) begin
      aw_got <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      w_got <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data are captured straight from the register mux, so reads have no side effects
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nfcs_mapped(s_axi_araddr) ? rif.rd_data : 32'h0000_0000;
      s_axi_rresp <= nfcs_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : nfcs_axil_slave
`default_nettype wire

// file: verification/nfcs_flash_model.sv
// Behavioural NOR flash array answering the controller's operation handshake
`timescale 1ns/1ps
`default_nettype none
module nfcs_flash_model (
  input wire logic mclk,
  input wire logic nor_reset_n,
  input wire logic nor_op_req,
  input wire logic [3:0] dly,
  input wire logic [7:0] dq_set,
  output logic flash_busy_handshake_n,
  output logic nor_array_ready,
  output logic [7:0] flash_dq
);
  logic busy;
  initial begin
    busy = 1'b0;
    flash_busy_handshake_n = 1'b1;
  end
  // Busy while held in reset as well as during an operation
  assign nor_array_ready = !busy && nor_reset_n;
  // Lines flip while busy, so a stale mirror shows up
  assign flash_dq = busy ? ~dq_set : dq_set;
  always begin
    @(posedge mclk);
    if (nor_op_req) begin
      repeat (dly) @(posedge mclk);
      flash_busy_handshake_n <= 1'b0;
      busy <= 1'b1;
      // Low for 5+ edges: the two-flop sampling cannot miss it
      repeat (4 + dly) @(posedge mclk);
      flash_busy_handshake_n <= 1'b1;
      busy <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  end
endmodule : nfcs_flash_model
`default_nettype wire

// file: verification/nor_flash_ctrl_status_test.sv
// Self-checking bench of the NOR flash control and status block
`timescale 1ns/1ps
`default_nettype none
module nor_flash_ctrl_status_test;
  import nfcs_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, cmd;
  logic rst_n, req, busy_n, ardy;
  logic [21:0] sec;
  logic [31:0] wd;
  logic [7:0] dq;
  logic [7:0] dq_set = 8'h5A;
  logic [3:0] dly = 4'h1;
  logic [31:0] seed = 32'hD7ED;
  logic wh = 0, wl = 0, es = 0, irq = 0, done = 0;
  int fails = 0, num_checks = 0, cyc = 0, rst_lo = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) cyc++;
  always @(posedge mclk) if (!rst_n) rst_lo++;
  always @(posedge mclk) if (cyc > 40000) begin
    fails++;
    test_done();
  end
  nfcs_top nfcs_top_inst (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nor_reset_n(rst_n),
    .nor_op_req(req), .nor_op_cmd(cmd), .nor_sector(sec), .nor_wdata(wd),
    .flash_busy_handshake_n(busy_n), .nor_array_ready(ardy), .flash_dq(dq));
  nfcs_flash_model nfcs_flash_model_inst (.mclk(mclk), .nor_reset_n(rst_n), .nor_op_req(req),
    .dly(dly), .dq_set(dq_set), .flash_busy_handshake_n(busy_n), .nor_array_ready(ardy),
    .flash_dq(dq));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  function automatic logic [31:0] exp_st();
    return {20'h0, wh, wl, es, irq, dq_set[7], dq_set[6], dq_set[5], dq_set[3], dq_set[2],
      done, 2'h3};
  endfunction : exp_st
  task automatic chk_st();
    logic [31:0] d;
    logic [1:0] r;
    axr(32'(OFS_STATUS), d, r);
    chk(d, exp_st(), "status");
  endtask : chk_st
  task automatic run_op(input logic [1:0] op, input logic [21:0] s, input logic ok);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    axw(32'(OFS_SECTOR), {10'h0, s}, r);
    axw(32'(OFS_WDATA), seed, r);
    axw(32'(OFS_COMMAND), {30'h0, op}, r);
    #1;
    chk({31'h0, req}, {31'h0, ok}, "op start");
    if (ok) begin
      chk({8'h0, sec, cmd}, {8'h0, s, op}, "op fields");
      chk(wd, seed, "op data");
      d = '0;
      while (d[ST_CIDLE] !== 1'b1 && n < 300) begin
        axr(32'(OFS_STATUS), d, r);
        n++;
        if (n == 1) chk({31'h0, d[ST_CIDLE]}, 32'h0, "busy bit");
      end
      chk({31'h0, d[ST_CIDLE]}, 32'h1, "op finish");
      wl = (op == OP_WRITE_LOW) || (wl && op != OP_WRITE_HIGH);
      wh = (op == OP_WRITE_HIGH) || (wh && op != OP_ERASE);
      es = (op == OP_ERASE) || es;
      done = 1'b1;
    end
    irq = 1'b1;
    chk_st();
  endtask : run_op
  task automatic test_done();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    axr(32'(OFS_CONTROL), d, r);
    chk(d, CONTROL_RESET, "control reset");
    axr(32'(OFS_SECTOR), d, r);
    chk(d, SECTOR_RESET, "sector reset");
    chk_st();
    axw(32'(OFS_STATUS), 32'hFFFF_FFFF, r);
    chk_st();
    axw(32'h20, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    axr(32'h40, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped read");
    seed = xs(seed);
    axw(32'(OFS_SECTOR), seed, r);
    axr(32'(OFS_SECTOR), d, r);
    chk(d, {10'h0, seed[21:0]}, "sector rw");
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      dly <= 4'(1 + seed[1:0]);
      dq_set <= seed[15:8];
      run_op(2'(i), 22'(seed[31:16]) | 22'h100, 1'b1);
    end
    $display("test operations done");
    axw(32'(OFS_CONTROL), 32'h80, r);
    run_op(OP_ERASE, PROT_SEC2, 1'b0);
    run_op(OP_WRITE_LOW, PROT_SEC0, 1'b0);
    run_op(OP_READ, PROT_SEC1, 1'b1);
    axw(32'(OFS_CONTROL), 32'h00, r);
    run_op(OP_ERASE, PROT_SEC3, 1'b1);
    $display("test lock done");
    axw(32'(OFS_CONTROL), 32'h01, r);
    done = 1'b0;
    irq = 1'b0;
    chk_st();
    rst_lo = 0;
    axw(32'(OFS_CONTROL), 32'h02, r);
    axr(32'(OFS_CONTROL), d, r);
    chk({31'h0, d[CTL_ARST]}, 32'h1, "array reset busy");
    repeat (120) @(posedge mclk);
    axr(32'(OFS_CONTROL), d, r);
    chk({31'h0, d[CTL_ARST]}, 32'h0, "array reset clear");
    chk(32'(rst_lo), 32'(ARST_CYCLES), "array reset length");
    axw(32'(OFS_CONTROL), 32'h00, r);
    chk_st();
    run_op(OP_WRITE_HIGH, 22'h3F_FFFF, 1'b1);
    $display("test resets done");
    test_done();
  end
endmodule : nor_flash_ctrl_status_test
`default_nettype wire
